//--- rcc_defines.svh
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH
// Register offsets
`define CTRL_OFF 12'h000
`define RATE_OFF 12'h004
`define STAT_OFF 12'h008
`define EQ_BASE 12'h020
`define DEM_BASE 12'h040
`define LANE_MASK 12'hFE3
// Field positions and masks
`define CTRL_IDLE_OVR 0
`define CTRL_PD_OVR 1
`define CTRL_IDLE_LSB 4
`define CTRL_PD_VAL 8
`define CTRL_MASK 9'h133
`define DEM_SWG_LSB 8
// Reset values
`define CTRL_RST 9'h000
`define RATE_RST 2'h2
`define EQ_RST 5'h00
`define DEM_RST 3'h0
`define SWG_RST 2'h0
// Timing
`define CLK_KHZ 20000
`define TIMEOUT_MS 25
`define STRETCH_MS 2
`define POR_MS 500
`endif

//--- repeater_pkg.sv
package repeater_pkg;
  typedef enum logic [1:0] {LVL_LO = 2'h0, LVL_HI = 2'h1, LVL_FLT = 2'h2} lvl_t;
  typedef enum logic [1:0] {RATE_3G = 2'h0, RATE_6G = 2'h1, RATE_AUTO = 2'h2} rate_t;
  // Three-level strap: above upper threshold, below lower, else floating
  function automatic lvl_t lvl(input logic up, input logic dn);
    if (up) return LVL_HI;
    if (dn) return LVL_LO;
    return LVL_FLT;
  endfunction
endpackage

//--- strap_if.sv
`timescale 1ns/1ps
interface strap_if;
  logic [3:0] eq_up;
  logic [3:0] eq_dn;
  logic [3:0] dem_up;
  logic [3:0] dem_dn;
  logic [9:0] eq_side;
  logic [5:0] dem_side;
  logic [3:0] swing_side;
  modport dec (input eq_up, eq_dn, dem_up, dem_dn, output eq_side, dem_side, swing_side);
  modport top (output eq_up, eq_dn, dem_up, dem_dn, input eq_side, dem_side, swing_side);
endinterface // strap_if

//--- strap_decoder.sv
`timescale 1ns/1ps
module strap_decoder (
  // Strap levels in, per-side settings out
  strap_if.dec s
);
  // Key is {high strap, low strap}; result is {gain_stage, boost_level}
  function automatic logic [4:0] eq_map(input repeater_pkg::lvl_t hi, input repeater_pkg::lvl_t lo);
    case ({hi, lo})
      4'hA: eq_map = 5'h00;
      4'h5: eq_map = 5'h0A;
      4'h0: eq_map = 5'h10;
      4'h8: eq_map = 5'h11;
      4'h9: eq_map = 5'h14;
      4'h1: eq_map = 5'h15;
      4'h4: eq_map = 5'h18;
      4'h2: eq_map = 5'h1A;
      4'h6: eq_map = 5'h1C;
      default: eq_map = 5'h00;
    endcase
  endfunction
  // De-emphasis level index; both floating is reserved and gives none
  function automatic logic [2:0] dem_map(input repeater_pkg::lvl_t d1, input repeater_pkg::lvl_t d0);
    case ({d1, d0})
      4'h1: dem_map = 3'h1;
      4'h4: dem_map = 3'h2;
      4'h5: dem_map = 3'h3;
      4'h2: dem_map = 3'h4;
      4'h6: dem_map = 3'h5;
      4'h8: dem_map = 3'h6;
      4'h9: dem_map = 3'h7;
      default: dem_map = 3'h0;
    endcase
  endfunction
  // Swing raised with de-emphasis: 1 = raised, 2 = raised plus extra step
  function automatic logic [1:0] swing_map(input logic [2:0] d);
    if (d == 3'h0) return 2'h0;
    if (d >= 3'h6) return 2'h2;
    return 2'h1;
  endfunction
  // ---------------------------------------------
  // Per-side decode
  // ---------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      s.eq_side[i*5 +: 5] = eq_map(repeater_pkg::lvl(s.eq_up[i*2+1], s.eq_dn[i*2+1]),
                                   repeater_pkg::lvl(s.eq_up[i*2], s.eq_dn[i*2]));
      s.dem_side[i*3 +: 3] = dem_map(repeater_pkg::lvl(s.dem_up[i*2+1], s.dem_dn[i*2+1]),
                                     repeater_pkg::lvl(s.dem_up[i*2], s.dem_dn[i*2]));
      s.swing_side[i*2 +: 2] = swing_map(s.dem_side[i*3 +: 3]);
    end
  end
endmodule // strap_decoder

//--- smbus_monitor.sv
`timescale 1ns/1ps
`include "rcc_defines.svh"
module smbus_monitor #(
  parameter int TIMEOUT_CYC = `TIMEOUT_MS * `CLK_KHZ,
  parameter int STRETCH_CYC = `STRETCH_MS * `CLK_KHZ,
  parameter int POR_CYC = `POR_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Synchronised bus lines and stretch request
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic stretch_req,
  // Status and clock-low drive
  output logic ready_q,
  output logic timeout_q,
  output logic scl_oe_q
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int SW = $clog2(STRETCH_CYC + 1);
  localparam int PW = $clog2(POR_CYC + 1);
  logic [TW-1:0] low_cnt_q;
  logic [SW-1:0] st_cnt_q;
  logic [PW-1:0] por_cnt_q;
  logic scl_p_q, sda_p_q, hold_q, msg_edge, oe_d;
  // Start or stop: data moves while clock stays high
  assign msg_edge = scl_s & scl_p_q & (sda_s ^ sda_p_q);
  assign oe_d = stretch_req & ready_q & ~timeout_q & (st_cnt_q < SW'(STRETCH_CYC));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
      hold_q <= 1'b0;
      timeout_q <= 1'b0;
    end else if (clk_en) begin
      timeout_q <= 1'b0;
      if (scl_s) begin
        low_cnt_q <= '0;
        hold_q <= 1'b0;
      end else if (!hold_q && low_cnt_q == TW'(TIMEOUT_CYC - 1)) begin
        timeout_q <= 1'b1;
        hold_q <= 1'b1;
      end else if (!hold_q) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cnt_q <= '0;
      scl_oe_q <= 1'b0;
    end else if (clk_en) begin
      scl_oe_q <= oe_d;
      if (msg_edge || timeout_q) st_cnt_q <= '0;
      else if (oe_d) st_cnt_q <= st_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (clk_en && !ready_q) begin
      if (por_cnt_q == PW'(POR_CYC - 1)) ready_q <= 1'b1;
      else por_cnt_q <= por_cnt_q + 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_timeout_a: assert property ($rose(timeout_q) |-> $past(low_cnt_q) == TW'(TIMEOUT_CYC - 1))
    else $error("timeout pulse without full clock-low count");
  stretch_cap_a: assert property (st_cnt_q == SW'(STRETCH_CYC) && !msg_edge && !timeout_q |=> !scl_oe_q)
    else $error("clock stretched past budget");
  por_ready_a: assert property ($rose(ready_q) |-> $past(por_cnt_q) == PW'(POR_CYC - 1))
    else $error("ready at wrong count");
  timeout_cv: cover property ($rose(timeout_q));
endmodule // smbus_monitor

//--- repeater_config_control.sv
`timescale 1ns/1ps
`include "rcc_defines.svh"

module repeater_config_control #(
  parameter int LANES = 4,
  parameter logic [2:0] ADDR_HIGH = 3'h5,
  parameter int TIMEOUT_CYC = `TIMEOUT_MS * `CLK_KHZ,
  parameter int STRETCH_CYC = `STRETCH_MS * `CLK_KHZ,
  parameter int POR_CYC = `POR_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode and control pins
  input wire logic bus_config_select,
  input wire logic power_down,
  input wire logic idle_threshold_pin_up,
  input wire logic idle_threshold_pin_dn,
  input wire logic rate_strap_up,
  input wire logic rate_strap_dn,
  // Strap pins, three-level pairs
  input wire logic [3:0] eq_strap_pins_up,
  input wire logic [3:0] eq_strap_pins_dn,
  input wire logic [3:0] deemph_strap_pins_up,
  input wire logic [3:0] deemph_strap_pins_dn,
  // Management bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  // Byte engine hooks
  input wire logic stretch_req,
  output logic [6:0] slave_addr,
  output logic smbus_ready,
  output logic smbus_timeout,
  // Applied settings
  output logic [10*LANES-1:0] eq_setting,
  output logic [6*LANES-1:0] deemph_level,
  output logic [4*LANES-1:0] output_swing,
  output logic [1:0] rate_sel,
  output logic [1:0] idle_thr,
  output logic pd_eff
);
  localparam int CH = 2 * LANES;

  // ---------------------------------------------
  // Input synchronisers
  // ---------------------------------------------
  logic [23:0] async_in, sync1_q, sync2_q;
  logic mode_s, pd_s, scl_s, sda_s, mode_q;
  repeater_pkg::lvl_t rate_lvl, idle_lvl;

  assign async_in = {sda_i, scl_i, idle_threshold_pin_up, idle_threshold_pin_dn,
                     rate_strap_up, rate_strap_dn, deemph_strap_pins_up, deemph_strap_pins_dn,
                     eq_strap_pins_up, eq_strap_pins_dn, power_down, bus_config_select};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 24'h000000;
      sync2_q <= 24'h000000;
    end else if (clk_en) begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  assign mode_s = sync2_q[0];
  assign pd_s = sync2_q[1];
  assign rate_lvl = repeater_pkg::lvl(sync2_q[19], sync2_q[18]);
  assign idle_lvl = repeater_pkg::lvl(sync2_q[21], sync2_q[20]);
  assign scl_s = sync2_q[22];
  assign sda_s = sync2_q[23];

  // ---------------------------------------------
  // Strap decode
  // ---------------------------------------------
  strap_if s ();

  assign s.eq_dn = sync2_q[5:2];
  assign s.eq_up = sync2_q[9:6];
  assign s.dem_dn = sync2_q[13:10];
  assign s.dem_up = sync2_q[17:14];

  strap_decoder u_dec (
    .s (s.dec)
  );

  // ---------------------------------------------
  // Bus supervision
  // ---------------------------------------------
  smbus_monitor #(
    .TIMEOUT_CYC (TIMEOUT_CYC),
    .STRETCH_CYC (STRETCH_CYC),
    .POR_CYC (POR_CYC)
  ) u_mon (
    .pclk (pclk),
    .presetn (presetn),
    .clk_en (clk_en),
    .scl_s (scl_s),
    .sda_s (sda_s),
    .stretch_req (stretch_req),
    .ready_q (smbus_ready),
    .timeout_q (smbus_timeout),
    .scl_oe_q (scl_oe)
  );

  // ---------------------------------------------
  // Slave address capture
  // ---------------------------------------------
  logic [6:0] slave_addr_q;
  logic scl_o_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      slave_addr_q <= 7'h00;
      scl_o_q <= 1'b0;
    end else if (clk_en) begin
      mode_q <= mode_s;
      scl_o_q <= 1'b0;
      if (mode_s && !mode_q) begin
        slave_addr_q <= {ADDR_HIGH, sync2_q[15:14], sync2_q[7:6]};
      end
    end
  end

  assign slave_addr = slave_addr_q;
  assign scl_o = scl_o_q;

  // ---------------------------------------------
  // APB decode
  // ---------------------------------------------
  logic [8:0] ctrl_q;
  logic [1:0] rate_q;
  logic [4:0] eq_q [CH];
  logic [2:0] dem_q [CH];
  logic [1:0] swg_q [CH];
  logic [31:0] rd_d, prdata_q;
  logic map_ok, pready_q, pslverr_q, apb_acc, apb_wr;
  logic [2:0] idx;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    return (a & `LANE_MASK) == base && int'(a[4:2]) < CH;
  endfunction

  assign apb_acc = psel & penable;
  assign apb_wr = apb_acc & pwrite & pready_q;
  assign idx = paddr[4:2];

  always_comb begin
    rd_d = 32'h00000000;
    map_ok = 1'b1;
    if (paddr == `CTRL_OFF) begin
      rd_d = {23'h000000, ctrl_q};
    end else if (paddr == `RATE_OFF) begin
      rd_d = {30'h00000000, rate_q};
    end else if (paddr == `STAT_OFF) begin
      rd_d = {21'h000000, rate_sel, idle_thr, pd_eff, smbus_ready, slave_addr_q[3:0], mode_s};
    end else if (hit(paddr, `EQ_BASE)) begin
      rd_d = {27'h0000000, eq_q[idx]};
    end else if (hit(paddr, `DEM_BASE)) begin
      rd_d = {22'h000000, swg_q[idx], 5'h00, dem_q[idx]};
    end else begin
      map_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (clk_en) begin
      pready_q <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~map_ok;
      prdata_q <= (apb_acc & ~pready_q & ~pwrite) ? rd_d : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      rate_q <= `RATE_RST;
      for (int c = 0; c < CH; c++) begin
        eq_q[c] <= `EQ_RST;
        dem_q[c] <= `DEM_RST;
        swg_q[c] <= `SWG_RST;
      end
    end else if (clk_en) begin
      if (!mode_s) begin
        ctrl_q <= `CTRL_RST;
        rate_q <= `RATE_RST;
        for (int c = 0; c < CH; c++) begin
          eq_q[c] <= `EQ_RST;
          dem_q[c] <= `DEM_RST;
          swg_q[c] <= `SWG_RST;
        end
      end else if (apb_wr) begin
        // Power-down plays no part here, so contents persist through it
        if (paddr == `CTRL_OFF) ctrl_q <= pwdata[8:0] & `CTRL_MASK;
        if (paddr == `RATE_OFF) rate_q <= pwdata[1:0];
        if (hit(paddr, `EQ_BASE)) eq_q[idx] <= pwdata[4:0];
        if (hit(paddr, `DEM_BASE)) begin
          dem_q[idx] <= pwdata[2:0];
          swg_q[idx] <= pwdata[`DEM_SWG_LSB +: 2];
        end
      end
    end
  end

  // ---------------------------------------------
  // Applied settings
  // ---------------------------------------------
  logic [10*LANES-1:0] eq_setting_q;
  logic [6*LANES-1:0] deemph_q;
  logic [4*LANES-1:0] swing_q;
  logic [1:0] rate_sel_q, idle_thr_q, rate_pin;
  logic pd_eff_q;

  always_comb begin
    case (rate_lvl)
      repeater_pkg::LVL_LO: rate_pin = repeater_pkg::RATE_3G;
      repeater_pkg::LVL_HI: rate_pin = repeater_pkg::RATE_6G;
      default: rate_pin = repeater_pkg::RATE_AUTO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_setting_q <= '0;
      deemph_q <= '0;
      swing_q <= '0;
      rate_sel_q <= `RATE_RST;
    end else if (clk_en) begin
      for (int c = 0; c < CH; c++) begin
        if (mode_s) begin
          eq_setting_q[c*5 +: 5] <= eq_q[c];
          deemph_q[c*3 +: 3] <= dem_q[c];
          swing_q[c*2 +: 2] <= swg_q[c];
        end else begin
          eq_setting_q[c*5 +: 5] <= s.eq_side[(c%2)*5 +: 5];
          deemph_q[c*3 +: 3] <= s.dem_side[(c%2)*3 +: 3];
          swing_q[c*2 +: 2] <= s.swing_side[(c%2)*2 +: 2];
        end
      end
      rate_sel_q <= mode_s ? rate_q : rate_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_thr_q <= 2'h2;
      pd_eff_q <= 1'b0;
    end else if (clk_en) begin
      idle_thr_q <= (mode_s && ctrl_q[`CTRL_IDLE_OVR]) ? ctrl_q[`CTRL_IDLE_LSB +: 2] : idle_lvl;
      pd_eff_q <= (mode_s && ctrl_q[`CTRL_PD_OVR]) ? ctrl_q[`CTRL_PD_VAL] : pd_s;
    end
  end

  assign eq_setting = eq_setting_q;
  assign deemph_level = deemph_q;
  assign output_swing = swing_q;
  assign rate_sel = rate_sel_q;
  assign idle_thr = idle_thr_q;
  assign pd_eff = pd_eff_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pin_eq_a: assert property (clk_en && !mode_s |=> eq_setting_q[4:0] == $past(s.eq_side[4:0])
    && eq_setting_q[9:5] == $past(s.eq_side[9:5]))
    else $error("strap equalizer not applied per side");
  reg_eq_a: assert property (clk_en && mode_s |=> eq_setting_q[5*CH-1 -: 5] == $past(eq_q[CH-1]))
    else $error("register equalizer not applied");
  reg_reset_a: assert property (clk_en && !mode_s |=> eq_q[3] == `EQ_RST && rate_q == `RATE_RST
    && ctrl_q == `CTRL_RST)
    else $error("registers not at default in strap mode");
  pd_retain_a: assert property (clk_en && mode_s && !apb_wr |=> eq_q[0] == $past(eq_q[0])
    && dem_q[0] == $past(dem_q[0]))
    else $error("register contents lost in register mode");
  pd_override_a: assert property (clk_en && mode_s && ctrl_q[`CTRL_PD_OVR] |=> pd_eff_q == $past(ctrl_q[`CTRL_PD_VAL]))
    else $error("override not honoured");
  addr_capture_a: assert property (clk_en && mode_s && !mode_q |=> slave_addr_q[3:0]
    == $past({sync2_q[15:14], sync2_q[7:6]}))
    else $error("slave address not captured");
  swing_raise_a: assert property (s.dem_side[2:0] != 3'h0 |-> s.swing_side[1:0] != 2'h0)
    else $error("swing not raised with de-emphasis");
  eq_bypass_a: assert property (s.eq_up[1:0] == 2'h0 && s.eq_dn[1:0] == 2'h0 |-> s.eq_side[4:0] == 5'h00)
    else $error("floating straps not bypass");
  eq_high_a: assert property (s.eq_up[1:0] == 2'h3 |-> s.eq_side[4:0] == 5'h0A)
    else $error("high straps wrong code");
  eq_low_a: assert property (s.eq_dn[1:0] == 2'h3 && s.eq_up[1:0] == 2'h0 |-> s.eq_side[4:0] == 5'h10)
    else $error("low straps wrong code");
  rate_auto_a: assert property (clk_en && !mode_s && rate_lvl == repeater_pkg::LVL_FLT
    |=> rate_sel_q == repeater_pkg::RATE_AUTO)
    else $error("floating rate strap not automatic");
  apb_answer_a: assert property (apb_acc && !pready_q && clk_en |=> pready_q ##1 !pready_q || !clk_en)
    else $error("APB answer timing");

  mode_enter_cv: cover property (clk_en && mode_s && !mode_q);
  reg_write_cv: cover property (apb_wr && mode_s && hit(paddr, `EQ_BASE));
  override_cv: cover property (mode_s && ctrl_q[`CTRL_IDLE_OVR] && clk_en);

endmodule // repeater_config_control

//--- board_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board straps and bus host
// ----------------------------------------
module board_host_model (
  // Requested strap levels, two bits a pin
  input wire logic [7:0] eq_lvl,
  input wire logic [7:0] dem_lvl,
  // Host clock hold and device stretch
  input wire logic host_scl_low,
  input wire logic scl_oe,
  // Strap pin pairs
  output logic [3:0] eq_up,
  output logic [3:0] eq_dn,
  output logic [3:0] dem_up,
  output logic [3:0] dem_dn,
  // Bus lines
  output logic scl,
  output logic sda
);
  // Floating pin drives neither comparator
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eq_up[i] = eq_lvl[2*i+:2] == repeater_pkg::LVL_HI;
      eq_dn[i] = eq_lvl[2*i+:2] == repeater_pkg::LVL_LO;
      dem_up[i] = dem_lvl[2*i+:2] == repeater_pkg::LVL_HI;
      dem_dn[i] = dem_lvl[2*i+:2] == repeater_pkg::LVL_LO;
    end
  end
  // Pulled-up lines, low only while someone holds them
  assign scl = !(host_scl_low || scl_oe);
  assign sda = 1'b1;
endmodule // board_host_model

//--- repeater_config_control_tb_top.sv
`timescale 1ns/1ps
module repeater_config_control_tb_top;
  localparam int TMO = 20;
  localparam int STR = 8;
  localparam int POR = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic bus_config_select = 1'b0, power_down = 1'b0, host_low = 1'b0, stretch_req = 1'b0, clk_en = 1'b1;
  logic idle_up = 1'b0, idle_dn = 1'b0, rate_up = 1'b0, rate_dn = 1'b0;
  logic [7:0] eq_lvl = 8'hAA, dem_lvl = 8'hAA;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scl_oe, scl_o, scl, sda, smbus_ready, smbus_timeout, pd_eff, err;
  logic [3:0] eq_up, eq_dn, dem_up, dem_dn;
  logic [6:0] slave_addr;
  logic [39:0] eq_setting;
  logic [23:0] deemph_level;
  logic [15:0] output_swing;
  logic [1:0] rate_sel, idle_thr;
  logic [3:0] eq_pin [6] = '{4'hA, 4'h5, 4'h0, 4'h8, 4'h9, 4'h1};
  logic [4:0] eq_exp [6] = '{5'h00, 5'h0A, 5'h10, 5'h11, 5'h14, 5'h15};
  logic [3:0] dem_pin [4] = '{4'h0, 4'h1, 4'h9, 4'hA};
  logic [4:0] dem_exp [4] = '{5'h00, 5'h09, 5'h17, 5'h00};
  logic [1:0] rate_exp [3] = '{2'h1, 2'h0, 2'h2};
  int mismatches = 0;
  int num_checks = 0;
  int n;

  initial begin
    forever #25 pclk = ~pclk;
  end

  board_host_model host (.eq_lvl(eq_lvl), .dem_lvl(dem_lvl), .host_scl_low(host_low), .scl_oe(scl_oe),
    .eq_up(eq_up), .eq_dn(eq_dn), .dem_up(dem_up), .dem_dn(dem_dn), .scl(scl), .sda(sda));

  repeater_config_control #(.TIMEOUT_CYC(TMO), .STRETCH_CYC(STR), .POR_CYC(POR)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_config_select(bus_config_select), .power_down(power_down), .idle_threshold_pin_up(idle_up),
    .idle_threshold_pin_dn(idle_dn), .rate_strap_up(rate_up), .rate_strap_dn(rate_dn),
    .eq_strap_pins_up(eq_up), .eq_strap_pins_dn(eq_dn), .deemph_strap_pins_up(dem_up),
    .deemph_strap_pins_dn(dem_dn), .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe),
    .stretch_req(stretch_req), .slave_addr(slave_addr), .smbus_ready(smbus_ready),
    .smbus_timeout(smbus_timeout), .eq_setting(eq_setting), .deemph_level(deemph_level),
    .output_swing(output_swing), .rate_sel(rate_sel), .idle_thr(idle_thr), .pd_eff(pd_eff));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wcyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    wcyc(16);
    presetn <= 1'b1;
    n = 0;
    while (smbus_ready !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    chk("ready delay", 1, n <= POR + 4);
    if (smbus_ready !== 1'b1) summarize();
    chk("rate default", 2, rate_sel);
    chk("idle float", 2, idle_thr);
    chk("eq bypass", 0, 32'(eq_setting != 40'h0));
    for (int i = 0; i < 6; i++) begin
      eq_lvl <= {4'hA, eq_pin[i]};
      wcyc(5);
      chk("eq side a", eq_exp[i], eq_setting[4:0]);
      chk("eq side b", 0, eq_setting[9:5]);
      chk("eq ch2", eq_exp[i], eq_setting[14:10]);
    end
    for (int i = 0; i < 4; i++) begin
      dem_lvl <= {4'hA, dem_pin[i]};
      wcyc(5);
      chk("deemph swing", dem_exp[i], {output_swing[1:0], deemph_level[2:0]});
    end
    for (int i = 0; i < 3; i++) begin
      rate_up <= i == 0;
      rate_dn <= i == 1;
      wcyc(5);
      chk("rate strap", rate_exp[i], rate_sel);
    end
    rate_up <= 1'b1;
    idle_up <= 1'b1;
    eq_lvl <= 8'hA5;
    dem_lvl <= 8'hA6;
    wcyc(5);
    bus_config_select <= 1'b1;
    wcyc(5);
    chk("reg eq", 0, eq_setting[4:0]);
    chk("reg rate", 2, rate_sel);
    chk("slave addr", 7'h5B, slave_addr);
    apb(1'b0, 12'h008, 0);
    chk("status", 32'h0000_04B7, rd);
    apb(1'b1, 12'h02C, 32'h0000_001F);
    apb(1'b1, 12'h054, 32'h0000_0304);
    apb(1'b1, 12'h004, 32'h0000_0000);
    wcyc(3);
    chk("eq ch3", 5'h1F, eq_setting[19:15]);
    chk("eq ch2 reg", 0, eq_setting[14:10]);
    chk("deemph ch5", 3'h4, deemph_level[17:15]);
    chk("swing ch5", 2'h3, output_swing[11:10]);
    chk("rate reg", 0, rate_sel);
    apb(1'b0, 12'h02C, 0);
    chk("eq readback", 32'h0000_001F, rd);
    apb(1'b0, 12'h100, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    chk("idle pin", 1, idle_thr);
    apb(1'b1, 12'h000, 32'h0000_0001);
    wcyc(3);
    chk("idle override", 0, idle_thr);
    power_down <= 1'b1;
    wcyc(5);
    chk("pd pin", 1, pd_eff);
    apb(1'b1, 12'h000, 32'h0000_0003);
    wcyc(3);
    chk("pd override", 0, pd_eff);
    chk("eq kept", 5'h1F, eq_setting[19:15]);
    power_down <= 1'b0;
    bus_config_select <= 1'b0;
    wcyc(5);
    chk("idle pin back", 1, idle_thr);
    chk("strap eq back", 5'h0A, eq_setting[4:0]);
    bus_config_select <= 1'b1;
    wcyc(5);
    apb(1'b0, 12'h02C, 0);
    chk("eq reset", 0, rd);
    apb(1'b0, 12'h000, 0);
    chk("ctrl reset", 0, rd);
    stretch_req <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      n += int'(scl_oe === 1'b1);
    end
    chk("stretch total", STR, n);
    chk("scl drive", 0, scl_o);
    stretch_req <= 1'b0;
    wcyc(4);
    host_low <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (smbus_timeout !== 1'b1 && n < 100);
    chk("timeout delay", 1, n >= TMO && n <= TMO * 35 / 25);
    if (smbus_timeout !== 1'b1) summarize();
    @(posedge pclk);
    chk("timeout pulse", 0, smbus_timeout);
    host_low <= 1'b0;
    wcyc(4);
    clk_en <= 1'b0;
    bus_config_select <= 1'b0;
    wcyc(6);
    chk("frozen eq", 0, eq_setting[4:0]);
    clk_en <= 1'b1;
    wcyc(5);
    chk("eq after enable", 5'h0A, eq_setting[4:0]);
    summarize();
  end
endmodule // repeater_config_control_tb_top
